// ---- hdl/ufc_forward_ctrl.sv ----
// global forwarding policy registers and the decisions they steer
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_forward_ctrl
   import ufc_pkg::*;
#(
   parameter int NUM_PORTS = 5,
   parameter int RLP0_CYC = `UFC_RLP0_MS * `UFC_CLK_KHZ,
   parameter int RLP1_CYC = `UFC_RLP1_MS * `UFC_CLK_KHZ,
   parameter int RLP2_CYC = `UFC_RLP2_MS * `UFC_CLK_KHZ
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic fwd_valid,
   input wire ufc_class_e fwd_class,
   input wire logic [NUM_PORTS-1:0] fwd_default_mask,
   output logic fwd_done,
   output logic [NUM_PORTS-1:0] fwd_port_mask,
   output logic fwd_drop,
   input wire logic [47:0] own_addr,
   input wire logic eg_valid,
   input wire logic [47:0] eg_dst_addr,
   output logic eg_done,
   output logic eg_drop,
   input wire logic tos_valid,
   input wire logic [7:0] tos_byte,
   output logic pri_done,
   output logic [1:0] pri_value,
   output logic rate_tick,
   output logic egress_queue_based,
   input wire logic tag_valid,
   input wire logic [2:0] tag_src_port,
   input wire logic [NUM_PORTS-1:0] pvid_insert_bits,
   input wire logic [NUM_PORTS*NUM_PORTS-1:0] src_insert_matrix,
   output logic tag_done,
   output logic [NUM_PORTS-1:0] tag_insert_mask
);

   logic [7:0] mcast_reg;
   logic [7:0] vid_reg;
   logic [7:0] ipmc_reg;
   logic [7:0] rate_reg;
   logic [7:0] dscp_reg [`UFC_DSCP_REGS];
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [31:0] rl_cnt_reg;
   logic [31:0] rl_cnt_next;
   logic tick_reg;
   logic [NUM_PORTS-1:0] fwd_mask_reg;
   logic [NUM_PORTS-1:0] fwd_mask_next;
   logic fwd_done_reg;
   logic eg_done_reg;
   logic eg_drop_reg;
   logic pri_done_reg;
   logic [1:0] pri_reg;
   logic tag_done_reg;
   logic [NUM_PORTS-1:0] tag_reg;
   logic [NUM_PORTS-1:0] tag_next;

   // address decode
   wire hit_mcast = (reg_addr == `UFC_OFS_MCAST);
   wire hit_vid = (reg_addr == `UFC_OFS_VID);
   wire hit_ipmc = (reg_addr == `UFC_OFS_IPMC);
   wire hit_rate = (reg_addr == `UFC_OFS_RATE);
   wire hit_dscp = ((reg_addr >> 4) == (`UFC_OFS_DSCP_BASE >> 4));
   wire [3:0] dscp_idx = reg_addr[3:0];

   // reserved bits keep their defaults whatever software writes
   wire [7:0] wr_mcast = (reg_wdata & ~`UFC_RO_MCAST) | (`UFC_RST_MCAST & `UFC_RO_MCAST);
   wire [7:0] wr_vid = (reg_wdata & ~`UFC_RO_VID) | (`UFC_RST_VID & `UFC_RO_VID);
   wire [7:0] wr_ipmc = (reg_wdata & ~`UFC_RO_IPMC) | (`UFC_RST_IPMC & `UFC_RO_IPMC);
   wire [7:0] wr_rate = (reg_wdata & ~`UFC_RO_RATE) | (`UFC_RST_RATE & `UFC_RO_RATE);

   // control registers; enables reset to zero, period field to 01
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         mcast_reg <= `UFC_RST_MCAST;
         vid_reg <= `UFC_RST_VID;
         ipmc_reg <= `UFC_RST_IPMC;
         rate_reg <= `UFC_RST_RATE;
      end
      else if (reg_wr)
      begin
         if (hit_mcast) mcast_reg <= wr_mcast;
         if (hit_vid) vid_reg <= wr_vid;
         if (hit_ipmc) ipmc_reg <= wr_ipmc;
         if (hit_rate) rate_reg <= wr_rate;
      end
   end

   // code point priority table, one byte holds four 2-bit entries
   genvar gi;
   generate
      for (gi = 0; gi < `UFC_DSCP_REGS; gi++)
      begin : g_dscp
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
               dscp_reg[gi] <= `UFC_RST_DSCP;
            else if (reg_wr && hit_dscp && dscp_idx == 4'(gi))
               dscp_reg[gi] <= reg_wdata;
         end
      end
   endgenerate

   // read mux; unmapped addresses read as zero
   always_comb
   begin
      if (!reg_rd)
         rdata_next = 8'h00;
      else if (hit_mcast)
         rdata_next = mcast_reg;
      else if (hit_vid)
         rdata_next = vid_reg;
      else if (hit_ipmc)
         rdata_next = ipmc_reg;
      else if (hit_rate)
         rdata_next = rate_reg;
      else if (hit_dscp)
         rdata_next = dscp_reg[dscp_idx];
      else
         rdata_next = 8'h00;
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end
   assign reg_rdata = rdata_reg;

   // unknown-destination steering: an enabled class uses its mask as is,
   // bit 3 included, since software owns that bit's meaning
   wire mcast_en = mcast_reg[`UFC_EN_BIT];
   wire vid_en = vid_reg[`UFC_EN_BIT];
   wire ipmc_en = ipmc_reg[`UFC_EN_BIT];
   wire cls_en = (fwd_class == ufc_cls_mcast) ? mcast_en :
                 (fwd_class == ufc_cls_vid) ? vid_en :
                 (fwd_class == ufc_cls_ipmc) ? ipmc_en : 1'b0;
   wire [7:0] cls_reg = (fwd_class == ufc_cls_mcast) ? mcast_reg :
                        (fwd_class == ufc_cls_vid) ? vid_reg : ipmc_reg;
   // mask picks ports, zero drops
   assign fwd_mask_next = cls_en ? cls_reg[NUM_PORTS-1:0] : fwd_default_mask;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         fwd_done_reg <= 1'b0;
         fwd_mask_reg <= '0;
      end
      else
      begin
         fwd_done_reg <= fwd_valid;
         if (fwd_valid) fwd_mask_reg <= fwd_mask_next;
      end
   end
   assign fwd_done = fwd_done_reg;
   assign fwd_port_mask = fwd_mask_reg;
   assign fwd_drop = fwd_done_reg && (fwd_mask_reg == '0);

   // self-address filter, checked per egress port against the own address
   wire self_filt = ipmc_reg[`UFC_SELF_FILT_BIT];
   wire self_hit = (eg_dst_addr == own_addr);
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         eg_done_reg <= 1'b0;
         eg_drop_reg <= 1'b0;
      end
      else
      begin
         eg_done_reg <= eg_valid;
         eg_drop_reg <= eg_valid && self_filt && self_hit;
      end
   end
   assign eg_done = eg_done_reg;
   assign eg_drop = eg_drop_reg;

   // ingress rate limit time base; the >= compare lets a shorter period
   // written mid-count take effect without waiting out the old one
   wire ufc_rlp_t rlp = rate_reg[`UFC_RLP_LSB +: 2];
   wire [31:0] rl_limit = rlp[1] ? 32'(RLP2_CYC) :
                          rlp[0] ? 32'(RLP1_CYC) : 32'(RLP0_CYC);
   wire rl_wrap = (rl_cnt_reg >= rl_limit - 32'd1);
   assign rl_cnt_next = rl_wrap ? 32'd0 : rl_cnt_reg + 32'd1;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rl_cnt_reg <= 32'd0;
         tick_reg <= 1'b0;
      end
      else
      begin
         rl_cnt_reg <= rl_cnt_next;
         tick_reg <= rl_wrap;
      end
   end
   assign rate_tick = tick_reg;
   assign egress_queue_based = rate_reg[`UFC_QBASED_BIT];

   // code point lookup: upper six TOS bits pick byte and bit pair
   wire [7:0] dscp_byte = dscp_reg[tos_byte[7:4]];
   wire [1:0] dscp_pri = dscp_byte[{tos_byte[3:2], 1'b0} +: 2];
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         pri_done_reg <= 1'b0;
         pri_reg <= 2'h0;
      end
      else
      begin
         pri_done_reg <= tos_valid;
         if (tos_valid) pri_reg <= dscp_pri;
      end
   end
   assign pri_done = pri_done_reg;
   assign pri_value = pri_reg;

   // default tag insertion per egress port
   wire src_sel = rate_reg[`UFC_SRC_TAG_BIT];
   generate
      for (gi = 0; gi < NUM_PORTS; gi++)
      begin : g_tag
         // row gi of the matrix holds egress port gi's per-source bits
         wire [NUM_PORTS-1:0] row = src_insert_matrix[gi*NUM_PORTS +: NUM_PORTS];
         assign tag_next[gi] = src_sel ? row[tag_src_port] :
                               pvid_insert_bits[gi];
      end
   endgenerate
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         tag_done_reg <= 1'b0;
         tag_reg <= '0;
      end
      else
      begin
         tag_done_reg <= tag_valid;
         if (tag_valid) tag_reg <= tag_next;
      end
   end
   assign tag_done = tag_done_reg;
   assign tag_insert_mask = tag_reg;

   // gap counter between ticks, only for checking
   logic [31:0] gap_reg;
   logic seen_tick_reg;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || (reg_wr && hit_rate))
      begin
         gap_reg <= 32'd0;
         seen_tick_reg <= 1'b0;
      end
      else if (tick_reg)
      begin
         gap_reg <= 32'd1;
         seen_tick_reg <= 1'b1;
      end
      else
         gap_reg <= gap_reg + 32'd1;
   end

   sequence s_rate_write;
      reg_wr && hit_rate;
   endsequence
   sequence s_rate_readback;
      reg_rd && hit_rate;
   endsequence
   // every read of the rate register shows its reserved bits at zero
   a_reserved_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_rate_readback |=> (reg_rdata & `UFC_RO_RATE) == 8'h00)
      else $error("reserved rate bits not zero on read");
   a_mcast_steer: assert property (@(posedge core_clk) disable iff (sys_rst)
      fwd_valid && fwd_class == ufc_cls_mcast && mcast_en
      |=> fwd_done && fwd_port_mask == $past(mcast_reg[NUM_PORTS-1:0]))
      else $error("unknown multicast mask not applied");
   a_vid_steer: assert property (@(posedge core_clk) disable iff (sys_rst)
      fwd_valid && fwd_class == ufc_cls_vid && vid_en
      |=> fwd_port_mask == $past(vid_reg[NUM_PORTS-1:0]))
      else $error("unknown vid mask not applied");
   a_ipmc_steer: assert property (@(posedge core_clk) disable iff (sys_rst)
      fwd_valid && fwd_class == ufc_cls_ipmc && ipmc_en
      |=> fwd_port_mask == $past(ipmc_reg[NUM_PORTS-1:0]) && fwd_drop == (fwd_port_mask == '0))
      else $error("unknown ip multicast mask not applied");
   a_disabled_default: assert property (@(posedge core_clk) disable iff (sys_rst)
      fwd_valid && !cls_en |=> fwd_port_mask == $past(fwd_default_mask))
      else $error("disabled class did not use default mask");
   a_self_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
      eg_valid |=> eg_drop == ($past(self_filt) && $past(eg_dst_addr) == $past(own_addr)))
      else $error("self address filter decision wrong");
   a_rate_period: assert property (@(posedge core_clk) disable iff (sys_rst)
      tick_reg && seen_tick_reg && $stable(rate_reg) |-> gap_reg == rl_limit)
      else $error("rate tick spacing differs from period");
   a_queue_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_rate_write |=> egress_queue_based == $past(reg_wdata[`UFC_QBASED_BIT]))
      else $error("egress limit mode not following write");
   a_tag_choice: assert property (@(posedge core_clk) disable iff (sys_rst)
      tag_valid && !src_sel |=> tag_insert_mask == $past(pvid_insert_bits))
      else $error("global tag insertion mask wrong");
   // priority answers exactly one cycle after the query, from the table before any write
   a_tos_priority: assert property (@(posedge core_clk) disable iff (sys_rst)
      tos_valid |=> pri_done &&
      pri_value == $past(dscp_reg[tos_byte[7:4]][{tos_byte[3:2], 1'b0} +: 2]))
      else $error("code point priority wrong");
endmodule // ufc_forward_ctrl

// ---- shared/ufc_params.svh ----
// offsets, field positions, reset values and timing constants of the forwarding control bank
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

// register offsets on the management port
`define UFC_OFS_MCAST 8'h84
`define UFC_OFS_VID 8'h85
`define UFC_OFS_IPMC 8'h86
`define UFC_OFS_RATE 8'h87
`define UFC_OFS_DSCP_BASE 8'h90
`define UFC_DSCP_REGS 16

// field positions
`define UFC_MASK_W 5
`define UFC_EN_BIT 5
`define UFC_SELF_FILT_BIT 6
`define UFC_RLP_LSB 4
`define UFC_QBASED_BIT 3
`define UFC_SRC_TAG_BIT 2

// reset values, reserved bits included
`define UFC_RST_MCAST 8'h40
`define UFC_RST_VID 8'h00
`define UFC_RST_IPMC 8'h00
`define UFC_RST_RATE 8'h10
`define UFC_RST_DSCP 8'h00

// read-only (reserved) bit masks
`define UFC_RO_MCAST 8'hc0
`define UFC_RO_VID 8'hc0
`define UFC_RO_IPMC 8'h80
`define UFC_RO_RATE 8'hc3

// rate limit unit periods in ms and the core clock rate in kHz
`define UFC_CLK_KHZ 100000
`define UFC_RLP0_MS 16
`define UFC_RLP1_MS 64
`define UFC_RLP2_MS 256

`endif

// ---- shared/ufc_pkg.sv ----
// types shared by the forwarding control bank
package ufc_pkg;

   // class of a frame whose lookup failed
   typedef enum logic [1:0] {
      ufc_cls_mcast,
      ufc_cls_vid,
      ufc_cls_ipmc,
      ufc_cls_other
   } ufc_class_e;

   // code of the ingress rate limit period field
   typedef logic [1:0] ufc_rlp_t;

endpackage

// ---- sim/testbench.sv ----
// self-checking bench for the forwarding control bank
`timescale 1ns/1ps

module testbench;
   import ufc_pkg::*;
   logic core_clk, sys_rst, reg_wr, reg_rd, fwd_valid, fwd_done, fwd_drop;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, tos_byte, rv;
   ufc_class_e fwd_class;
   logic [4:0] fwd_default_mask, fwd_port_mask, pvid_insert_bits, tag_insert_mask;
   logic [47:0] own_addr, eg_dst_addr;
   logic eg_valid, eg_done, eg_drop, tos_valid, pri_done, rate_tick;
   logic egress_queue_based, tag_valid, tag_done;
   logic [1:0] pri_value;
   logic [2:0] tag_src_port;
   logic [24:0] src_insert_matrix;
   int error_cnt, num_checks, n;

   // short rate periods keep the run brief
   ufc_forward_ctrl #(.RLP0_CYC(16), .RLP1_CYC(64), .RLP2_CYC(256)) i_ufc_forward_ctrl
   (
      .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .fwd_valid, .fwd_class, .fwd_default_mask, .fwd_done, .fwd_port_mask, .fwd_drop,
      .own_addr, .eg_valid, .eg_dst_addr, .eg_done, .eg_drop, .tos_valid, .tos_byte,
      .pri_done, .pri_value, .rate_tick, .egress_queue_based, .tag_valid, .tag_src_port,
      .pvid_insert_bits, .src_insert_matrix, .tag_done, .tag_insert_mask
   );

   ufc_sw_model i_sw
   (
      .core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
   );

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one query pulse of group w; only that group may answer, one cycle later
   task automatic pulse(input int w);
      @(posedge core_clk);
      case (w)
         0: fwd_valid <= 1'b1;
         1: eg_valid <= 1'b1;
         2: tos_valid <= 1'b1;
         default: tag_valid <= 1'b1;
      endcase
      @(posedge core_clk);
      {fwd_valid, eg_valid, tos_valid, tag_valid} <= 4'h0;
      #1 chk("done", 4'h8 >> w, {fwd_done, eg_done, pri_done, tag_done});
   endtask

   task automatic t_regs;
      logic [7:0] rst [4] = '{8'h40, 8'h00, 8'h00, 8'h10};
      logic [7:0] ro [4] = '{8'hc0, 8'hc0, 8'h80, 8'hc3};
      for (int i = 0; i < 4; i++)
      begin
         i_sw.rd(8'h84 + i, rv);
         chk("reset", rst[i], rv);
         @(posedge core_clk);
         #1 chk("rd stands", 0, reg_rdata);
         i_sw.wr(8'h84 + i, 8'hff);
         i_sw.rd(8'h84 + i, rv);
         chk("ro bits", (8'hff & ~ro[i]) | (rst[i] & ro[i]), rv);
         i_sw.wr(8'h84 + i, rst[i]);
      end
      i_sw.wr(8'ha0, 8'h5a);
      i_sw.rd(8'ha0, rv);
      chk("unmapped", 0, rv);
      $display("test regs done");
   endtask

   task automatic t_fwd;
      logic [4:0] m [3] = '{5'h07, 5'h01, 5'h03};
      fwd_default_mask <= 5'h1a;
      for (int c = 0; c < 3; c++)
      begin
         fwd_class <= ufc_class_e'(c);
         i_sw.wr(8'h84 + c, {3'b001, m[c]});
         pulse(0);
         chk("mask", m[c], fwd_port_mask);
         i_sw.wr(8'h84 + c, 8'h3f);
         pulse(0);
         chk("flood", 5'h1f, fwd_port_mask);
         i_sw.wr(8'h84 + c, 8'h20);
         pulse(0);
         chk("drop", 6'h20, {fwd_drop, fwd_port_mask});
         i_sw.wr(8'h84 + c, 8'h1f);
         pulse(0);
         chk("off", 6'h1a, {fwd_drop, fwd_port_mask});
      end
      fwd_class <= ufc_cls_other;
      i_sw.wr(8'h84, 8'h3f);
      pulse(0);
      chk("other", 5'h1a, fwd_port_mask);
      $display("test fwd done");
   endtask

   task automatic t_own;
      own_addr <= 48'h0a1b2c3d4e5f;
      eg_dst_addr <= 48'h0a1b2c3d4e5f;
      i_sw.wr(8'h86, 8'h00);
      pulse(1);
      chk("eg off", 0, eg_drop);
      i_sw.wr(8'h86, 8'h40);
      pulse(1);
      chk("eg on", 1, eg_drop);
      eg_dst_addr <= 48'h0a1b2c3d4e5e;
      pulse(1);
      chk("eg diff", 0, eg_drop);
      $display("test own done");
   endtask

   task automatic t_pri;
      i_sw.wr(8'h91, 8'h08);
      i_sw.wr(8'h9f, 8'hc0);
      tos_byte <= 8'h17;
      pulse(2);
      chk("pri 5", 2, pri_value);
      tos_byte <= 8'h12;
      pulse(2);
      chk("pri 4", 0, pri_value);
      tos_byte <= 8'hfc;
      pulse(2);
      chk("pri 63", 3, pri_value);
      $display("test pri done");
   endtask

   task automatic t_tag;
      logic [4:0] e;
      pvid_insert_bits <= 5'h15;
      src_insert_matrix <= 25'h1a5c36b;
      i_sw.wr(8'h87, 8'h18);
      #1 chk("queue", 1, egress_queue_based);
      pulse(3);
      chk("global", 5'h15, tag_insert_mask);
      i_sw.wr(8'h87, 8'h14);
      #1 chk("port", 0, egress_queue_based);
      for (int s = 0; s < 5; s++)
      begin
         for (int k = 0; k < 5; k++)
            e[k] = src_insert_matrix[k * 5 + s];
         tag_src_port <= 3'(s);
         pulse(3);
         chk("per src", e, tag_insert_mask);
      end
      $display("test tag done");
   endtask

   // edges from one tick to the next, bounded
   task automatic gap(output int c);
      c = 0;
      do
      begin
         @(posedge core_clk);
         #1;
         c++;
      end
      while (rate_tick !== 1'b1 && c < 400);
   endtask

   task automatic t_rate;
      int p [4] = '{16, 64, 256, 256};
      for (int k = 0; k < 4; k++)
      begin
         i_sw.wr(8'h87, 8'(k << 4));
         gap(n);
         gap(n);
         chk("period", 16'(p[k]), 16'(n));
      end
      $display("test rate done");
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // hang guard, far beyond the expected run
   initial
   begin
      #100us;
      error_cnt++;
      finish_test;
   end

   initial
   begin
      error_cnt = 0;
      num_checks = 0;
      sys_rst = 1'b1;
      {fwd_valid, eg_valid, tos_valid, tag_valid} = 4'h0;
      fwd_class = ufc_cls_mcast;
      fwd_default_mask = 5'h00;
      own_addr = 48'h0;
      eg_dst_addr = 48'h1;
      tos_byte = 8'h00;
      tag_src_port = 3'h0;
      pvid_insert_bits = 5'h00;
      src_insert_matrix = 25'h0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_fwd;
      t_own;
      t_pri;
      t_tag;
      t_rate;
      finish_test;
   end
endmodule // testbench

// ---- sim/ufc_sw_model.sv ----
// software-side model driving the management register port
`timescale 1ns/1ps

module ufc_sw_model
(
   input logic core_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input logic [7:0] reg_rdata
);
   // bus idle from time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // one-cycle write; released lines go inverse so stale values cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // one-cycle read; data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule // ufc_sw_model
